// file: logic/cst_pkg.sv
package cst_pkg;
  // Link register addresses inside the charger
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_VREG = 2'h2;
  localparam logic [1:0] ADDR_CURR = 2'h3;
  // Control register fields
  localparam int CTRL_TERM_EN  = 0;
  localparam int CTRL_CE       = 1;
  localparam int CTRL_RESET    = 2;
  localparam int CTRL_KICK     = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [7:0] CTRL_RST_VAL = 8'h02;
  localparam logic [7:0] CTRL_WR_MASK = 8'h3B;
  // Current register fields; cap code 0 is the 100 mA setting
  localparam int CURR_CAP_LSB   = 0;
  localparam int CURR_FAST_LSB  = 2;
  localparam int CURR_TAPER_LSB = 6;
  localparam logic [7:0] CURR_RST_VAL = 8'h00;
  // Regulation voltage: 3.5 V plus 20 mV per code, code 47 is 4.44 V
  localparam logic [5:0] VREG_MAX_CODE = 6'h2F;
  localparam logic [7:0] VREG_RST_VAL  = 8'h02;
  // Operating modes
  localparam logic [1:0] MODE_CHARGE = 2'h0;
  localparam logic [1:0] MODE_BOOST  = 2'h1;
  localparam logic [1:0] MODE_HIZ    = 2'h2;
  // Condition codes
  localparam logic [2:0] COND_READY    = 3'h0;
  localparam logic [2:0] COND_CHARGING = 3'h1;
  localparam logic [2:0] COND_DONE     = 3'h2;
  localparam logic [2:0] COND_FAULT    = 3'h3;
  // Timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYC_DEF    = CYC_PER_US * TICK_US;
  localparam int LONG_MIN        = 32;
  localparam int LONG_TICKS_DEF  = LONG_MIN * 60 * (1_000_000 / TICK_US);
  localparam int SHORT_S         = 32;
  localparam int SHORT_TICKS_DEF = SHORT_S * (1_000_000 / TICK_US);
  localparam int FAULT_PULSE_US  = 128;
  localparam logic [11:0] FAULT_PULSE_CYC = 12'(CYC_PER_US * FAULT_PULSE_US);
  // Host-side AXI4-Lite map
  localparam logic [3:0] HOST_CMD_OFF = 4'h0;
  localparam logic [3:0] HOST_RES_OFF = 4'h4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {PH_OFF, PH_PRE, PH_FAST, PH_CV, PH_DONE, PH_FAULT} cst_phase_t;
  typedef enum logic [1:0] {H_IDLE, H_STB, H_WAIT} cst_hstate_t;
endpackage

// file: logic/cst_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cst_link_if;
  logic       wrStb;
  logic       rdStb;
  logic [1:0] addr;
  logic [7:0] wData;
  logic [7:0] rData;
  logic       statO;
  logic       statOe;
  wire        statLine;

  // Open-drain indicator with a pull-up
  assign statLine = statOe ? statO : 1'b1;

  modport dev (input wrStb, input rdStb, input addr, input wData, output rData, output statO, output statOe);
  modport host (output wrStb, output rdStb, output addr, output wData, input rData, input statLine);
endinterface
`default_nettype wire

// file: logic/cst_safety_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cst_safety_timer #(
  parameter int TICKS = 32
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic run,
  input  wire logic start,
  input  wire logic stop,
  output logic      active,
  output logic      expired
);
  logic [20:0] cnt_r;

  assign expired = active && run && tick && (cnt_r == 21'(TICKS - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 21'h000000;
      active <= 1'b0;
    end else if (start) begin
      cnt_r  <= 21'h000000;
      active <= 1'b1;
    end else if (stop || expired) begin
      active <= 1'b0;
    end else if (active && run && tick) begin
      cnt_r <= cnt_r + 21'h000001;
    end
  end
endmodule
`default_nettype wire

// file: logic/cst_charger_end.sv
// Operation
// - Below short threshold, precharge with fixed current
// - Ramp to fast current, limited by cap
// - Input cap defaults 100 mA, host reprograms
// - Regulation voltage register, 3.5 to 4.44 V
// - Terminate at taper level above recharge
// - Termination bit zero disables taper termination
// - Recharge below regulation minus offset
// - Automatic variant: power-up below weak restarts
// - Enable toggle or reset bit restarts
// - Long timer at start, stopped by writes
// - Short timer starts when a write stops long
// - Kick bit restarts short timer, self-clears
// - Short expiry: defaults, long restart, resume
// - Long expiry: charger off, fault code
// - Fault clears on reset; status held until read
// - Synchronous only above low-side current minimum
// - Modes charge, boost, high impedance only
// - Thermal shutdown stops switching, freezes timers
// - Fault emits one 128 us indicator pulse
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cst_charger_end
  import cst_pkg::*;
#(
  parameter int TICK_CYC     = TICK_CYC_DEF,
  parameter int LONG_TICKS   = LONG_TICKS_DEF,
  parameter int SHORT_TICKS  = SHORT_TICKS_DEF,
  parameter bit AUTO_VARIANT = 1'b1
) (
  input  wire logic  clk,
  input  wire logic  rst,
  cst_link_if.dev    link,
  input  wire logic  vbatBelowShort,
  input  wire logic  vbatBelowReg,
  input  wire logic  vbatBelowRecharge,
  input  wire logic  vbatBelowWeak,
  input  wire logic  taperReached,
  input  wire logic  vbusPorPulse,
  input  wire logic  lowSideAboveMin,
  input  wire logic  thermalShutdown,
  output logic       chargerOn,
  output logic       prechargeOn,
  output logic       boostOn,
  output logic       switchEn,
  output logic       syncRectOn,
  output logic [3:0] currentCode,
  output logic [1:0] inputCapCode,
  output logic [1:0] taperCode,
  output logic [5:0] regVoltageCode
);
  function automatic logic isCharging(input cst_phase_t p);
    return (p == PH_PRE) || (p == PH_FAST) || (p == PH_CV);
  endfunction

  // Fast-current code that a given input cap still allows
  function automatic logic [3:0] capLimit(input logic [1:0] cap);
    case (cap)
      2'h0:    return 4'h1;
      2'h1:    return 4'h6;
      2'h2:    return 4'hA;
      default: return 4'hF;
    endcase
  endfunction

  cst_phase_t  phase_r;
  cst_phase_t  phaseNxt;
  logic [7:0]  ctrl_r;
  logic [7:0]  vreg_r;
  logic [7:0]  curr_r;
  logic [14:0] tbCnt_r;
  logic        tick;
  logic [3:0]  ramp_r;
  logic [3:0]  rampTarget;
  logic [2:0]  cond_r;
  logic [2:0]  condNxt;
  logic        readSince_r;
  logic [11:0] pulseCnt_r;
  logic [7:0]  rData_r;
  logic        hostWr;
  logic        wrCtrl;
  logic        ceToggle;
  logic        resetSet;
  logic        loadDef;
  logic        newCycle;
  logic        allowed;
  logic        termDone;
  logic        chargeStart;
  logic        chargeEnd;
  logic        longActive;
  logic        longExpired;
  logic        shortActive;
  logic        shortExpired;
  logic        shortStart;
  logic [1:0]  mode;

  assign hostWr   = link.wrStb;
  assign wrCtrl   = hostWr && (link.addr == ADDR_CTRL);
  assign ceToggle = wrCtrl && (link.wData[CTRL_CE] != ctrl_r[CTRL_CE]);
  assign resetSet = wrCtrl && link.wData[CTRL_RESET];
  assign loadDef  = resetSet || shortExpired;
  assign mode     = ctrl_r[CTRL_MODE_LSB +: 2];
  assign allowed  = ctrl_r[CTRL_CE] && (mode == MODE_CHARGE);
  assign termDone = ctrl_r[CTRL_TERM_EN] && taperReached && !vbatBelowRecharge;

  assign newCycle = ceToggle || resetSet || shortExpired
                 || ((phase_r == PH_DONE) && vbatBelowRecharge)
                 || (AUTO_VARIANT && vbusPorPulse && vbatBelowWeak);

  // Shared time base for both timers; frozen in thermal shutdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbCnt_r <= 15'h0000;
    end else if (!thermalShutdown) begin
      tbCnt_r <= tick ? 15'h0000 : tbCnt_r + 15'h0001;
    end
  end
  assign tick = !thermalShutdown && (tbCnt_r == 15'(TICK_CYC - 1));

  // Register file reached over the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST_VAL;
      vreg_r <= VREG_RST_VAL;
      curr_r <= CURR_RST_VAL;
    end else if (loadDef) begin
      ctrl_r <= CTRL_RST_VAL;
      vreg_r <= VREG_RST_VAL;
      curr_r <= CURR_RST_VAL;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= link.wData & CTRL_WR_MASK;
      end else begin
        ctrl_r[CTRL_KICK] <= 1'b0;
      end
      if (hostWr && (link.addr == ADDR_VREG)) begin
        // Codes past 4.44 V are clamped rather than wrapped
        vreg_r <= (link.wData[5:0] > VREG_MAX_CODE) ? {2'h0, VREG_MAX_CODE} : {2'h0, link.wData[5:0]};
      end
      if (hostWr && (link.addr == ADDR_CURR)) begin
        curr_r <= link.wData;
      end
    end
  end

  always_comb begin
    phaseNxt = phase_r;
    case (phase_r)
      PH_FAULT: phaseNxt = PH_FAULT;
      default: begin
        if (longExpired) begin
          phaseNxt = PH_FAULT;
        end else if (!allowed) begin
          phaseNxt = PH_OFF;
        end else if ((phase_r == PH_DONE) && !newCycle) begin
          phaseNxt = PH_DONE;
        end else if ((phase_r == PH_CV) && !newCycle && termDone) begin
          phaseNxt = PH_DONE;
        end else if (vbatBelowShort) begin
          phaseNxt = PH_PRE;
        end else if (vbatBelowReg) begin
          phaseNxt = PH_FAST;
        end else begin
          phaseNxt = PH_CV;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_OFF;
    end else begin
      phase_r <= phaseNxt;
    end
  end

  assign chargeStart = (isCharging(phaseNxt) && !isCharging(phase_r)) || shortExpired;
  assign chargeEnd   = isCharging(phase_r) && !isCharging(phaseNxt);
  assign shortStart  = isCharging(phase_r) && !chargeStart
                    && ((hostWr && longActive) || ctrl_r[CTRL_KICK]);

  cst_safety_timer #(
    .TICKS (LONG_TICKS)
  ) longTimer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .run     (!thermalShutdown),
    .start   (chargeStart),
    .stop    (hostWr || chargeEnd),
    .active  (longActive),
    .expired (longExpired)
  );

  cst_safety_timer #(
    .TICKS (SHORT_TICKS)
  ) shortTimer (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .run     (!thermalShutdown),
    .start   (shortStart),
    .stop    (chargeStart || chargeEnd),
    .active  (shortActive),
    .expired (shortExpired)
  );

  // Current steps up one code per tick toward the smaller of fast setting and cap; drops to it at once
  assign rampTarget = (curr_r[CURR_FAST_LSB +: 4] < capLimit(curr_r[CURR_CAP_LSB +: 2]))
                    ? curr_r[CURR_FAST_LSB +: 4] : capLimit(curr_r[CURR_CAP_LSB +: 2]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_r <= 4'h0;
    end else if (!((phase_r == PH_FAST) || (phase_r == PH_CV)) || loadDef) begin
      ramp_r <= 4'h0;
    end else if (ramp_r > rampTarget) begin
      ramp_r <= rampTarget;
    end else if (tick && (ramp_r < rampTarget)) begin
      ramp_r <= ramp_r + 4'h1;
    end
  end

  always_comb begin
    case (phase_r)
      PH_FAULT:              condNxt = COND_FAULT;
      PH_DONE:               condNxt = COND_DONE;
      PH_PRE, PH_FAST, PH_CV: condNxt = COND_CHARGING;
      default:               condNxt = COND_READY;
    endcase
  end

  // A new code waits until the host has read the previous one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cond_r <= COND_READY;
    end else if (readSince_r && (cond_r != condNxt)) begin
      cond_r <= condNxt;
    end
  end

  // A read in the same cycle as an update keeps the flag set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readSince_r <= 1'b1;
    end else if (link.rdStb && (link.addr == ADDR_STAT)) begin
      readSince_r <= 1'b1;
    end else if (cond_r != condNxt) begin
      readSince_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rData_r <= 8'h00;
    end else if (link.rdStb) begin
      case (link.addr)
        ADDR_CTRL: rData_r <= ctrl_r;
        ADDR_STAT: rData_r <= {3'h0, shortActive, longActive, cond_r};
        ADDR_VREG: rData_r <= vreg_r;
        default:   rData_r <= curr_r;
      endcase
    end
  end
  assign link.rData = rData_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulseCnt_r <= 12'h000;
    end else if ((phaseNxt == PH_FAULT) && (phase_r != PH_FAULT)) begin
      pulseCnt_r <= FAULT_PULSE_CYC;
    end else if (pulseCnt_r != 12'h000) begin
      pulseCnt_r <= pulseCnt_r - 12'h001;
    end
  end

  // Indicator pulled low while charging or during the fault pulse
  assign link.statO  = 1'b0;
  assign link.statOe = isCharging(phase_r) || (pulseCnt_r != 12'h000);

  assign chargerOn      = isCharging(phase_r);
  assign prechargeOn    = (phase_r == PH_PRE);
  assign boostOn        = ctrl_r[CTRL_CE] && (mode == MODE_BOOST) && (phase_r != PH_FAULT)
                       && !thermalShutdown;
  assign switchEn       = ((phase_r == PH_FAST) || (phase_r == PH_CV) || boostOn) && !thermalShutdown;
  assign syncRectOn     = switchEn && lowSideAboveMin;
  assign currentCode    = ramp_r;
  assign inputCapCode   = curr_r[CURR_CAP_LSB +: 2];
  assign taperCode      = curr_r[CURR_TAPER_LSB +: 2];
  assign regVoltageCode = vreg_r[5:0];
endmodule
`default_nettype wire

// file: logic/cst_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module cst_host_end
  import cst_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  cst_link_if.host         link
);
  function automatic logic isMapped(input logic [3:0] a);
    return (a == HOST_CMD_OFF) || (a == HOST_RES_OFF);
  endfunction

  cst_hstate_t st_r;
  logic [3:0]  awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic        doWrite;
  logic        cmdTake;
  logic        opRd_r;
  logic [1:0]  lAddr_r;
  logic [7:0]  lData_r;
  logic [7:0]  res_r;

  assign awready = !awHave_r;
  assign wready  = !wHave_r;
  assign arready = !rvalid;
  assign doWrite = awHave_r && wHave_r && !bvalid;
  // A command written while a transfer is under way is dropped
  assign cmdTake = doWrite && (awAddr_r == HOST_CMD_OFF) && (st_r == H_IDLE) && (wStrb_r[1:0] == 2'h3);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_r <= 1'b0;
      awAddr_r <= 4'h0;
    end else if (awvalid && awready) begin
      awHave_r <= 1'b1;
      awAddr_r <= awaddr;
    end else if (doWrite) begin
      awHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHave_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wHave_r <= 1'b1;
      wData_r <= wdata;
      wStrb_r <= wstrb;
    end else if (doWrite) begin
      wHave_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata  <= (araddr == HOST_RES_OFF) ? {22'h000000, link.statLine, (st_r != H_IDLE), res_r} : 32'h00000000;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r    <= H_IDLE;
      opRd_r  <= 1'b0;
      lAddr_r <= 2'h0;
      lData_r <= 8'h00;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (cmdTake) begin
            st_r    <= H_STB;
            opRd_r  <= wData_r[CMD_READ_BIT];
            lAddr_r <= wData_r[CMD_ADDR_LSB +: 2];
            lData_r <= wData_r[7:0];
          end
        end
        H_STB:   st_r <= H_WAIT;
        default: st_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_r <= 8'h00;
    end else if ((st_r == H_WAIT) && opRd_r) begin
      res_r <= link.rData;
    end
  end

  // Each link strobe is a single-cycle pulse
  assign link.wrStb = (st_r == H_STB) && !opRd_r;
  assign link.rdStb = (st_r == H_STB) && opRd_r;
  assign link.addr  = lAddr_r;
  assign link.wData = lData_r;
endmodule
`default_nettype wire

// file: verif/cst_link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cst_link_properties
  import cst_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [1:0] addr,
  input wire logic [7:0] wData,
  input wire logic [7:0] rData,
  input wire logic       statO,
  input wire logic       statOe,
  input wire logic       statLine
);
  logic statRd_r;
  logic faultSeen_r;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) statRd_r <= 1'b0;
    else statRd_r <= rdStb && (addr == ADDR_STAT);
  end

  // Once the host has seen a fault, every later status read before a reset must still show it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) faultSeen_r <= 1'b0;
    else if (statRd_r && rData[2:0] == COND_FAULT) faultSeen_r <= 1'b1;
  end

  chk_strobe_spacing: assert property ((wrStb || rdStb) |=> !(wrStb || rdStb) [*2])
    else $error("link strobes closer than three cycles");
  chk_strobe_exclusive: assert property (!(wrStb && rdStb))
    else $error("read and write strobe together");
  chk_wdata_held: assert property (wrStb |=> $stable(wData) && $stable(addr))
    else $error("write data or address moved after strobe");
  chk_rdata_hold: assert property (!rdStb |=> $stable(rData))
    else $error("read data changed without a read strobe");
  chk_drive_low: assert property (statO == 1'b0)
    else $error("indicator drive value not low");
  chk_line_pulled: assert property (statOe |-> !statLine)
    else $error("indicator line not low while enabled");
  chk_kick_selfclear: assert property (rdStb && addr == ADDR_CTRL |=> !rData[CTRL_KICK])
    else $error("kick bit read back as one");
  chk_reset_selfclear: assert property (rdStb && addr == ADDR_CTRL |=> !rData[CTRL_RESET])
    else $error("reset bit read back as one");
  chk_vreg_clamp: assert property (rdStb && addr == ADDR_VREG |=> rData[5:0] <= VREG_MAX_CODE)
    else $error("regulation code above maximum");
  chk_timers_apart: assert property (rdStb && addr == ADDR_STAT |=> !(rData[3] && rData[4]))
    else $error("both safety timers active");
  chk_fault_sticky: assert property (rdStb && addr == ADDR_STAT && faultSeen_r |=> rData[2:0] == COND_FAULT)
    else $error("fault code left status before reset");
endmodule
`default_nettype wire

// file: verif/charge_sequencer_safety_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module charge_sequencer_safety_timer_tb
  import cst_pkg::*;
;
  // Shortened time base: short 200 cycles, long 800 cycles
  localparam int TCK = 4;
  localparam int LTK = 200;
  localparam int STK = 50;
  localparam int SHORT_CYC = TCK * STK;
  localparam int LONG_CYC  = TCK * LTK;

  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb, currentCode;
  logic [31:0] wdata, rdata, resWord;
  logic [1:0]  bresp, rresp, inputCapCode, taperCode;
  logic        vbatBelowShort, vbatBelowReg, vbatBelowRecharge, vbatBelowWeak;
  logic        taperReached, vbusPorPulse, lowSideAboveMin, thermalShutdown;
  logic        chargerOn, prechargeOn, boostOn, switchEn, syncRectOn;
  logic [5:0]  regVoltageCode;
  logic [63:0] rexp;
  logic [1:0]  bq[$];
  logic [63:0] rq[$];
  int          bad_count, num_checks;
  integer      seed;

  cst_link_if link();
  cst_host_end i_cst_host_end (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(link));
  cst_charger_end #(.TICK_CYC(TCK), .LONG_TICKS(LTK), .SHORT_TICKS(STK), .AUTO_VARIANT(1'b1)) i_cst_charger_end (
    .clk(clk), .rst(rst), .link(link), .vbatBelowShort(vbatBelowShort), .vbatBelowReg(vbatBelowReg),
    .vbatBelowRecharge(vbatBelowRecharge), .vbatBelowWeak(vbatBelowWeak), .taperReached(taperReached),
    .vbusPorPulse(vbusPorPulse), .lowSideAboveMin(lowSideAboveMin), .thermalShutdown(thermalShutdown),
    .chargerOn(chargerOn), .prechargeOn(prechargeOn), .boostOn(boostOn), .switchEn(switchEn),
    .syncRectOn(syncRectOn), .currentCode(currentCode), .inputCapCode(inputCapCode), .taperCode(taperCode),
    .regVoltageCode(regVoltageCode));
  cst_link_properties i_cst_link_properties (.clk(clk), .rst(rst), .wrStb(link.wrStb), .rdStb(link.rdStb),
    .addr(link.addr), .wData(link.wData), .rData(link.rData), .statO(link.statO), .statOe(link.statOe),
    .statLine(link.statLine));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task chk1(input string nm, input logic seen, input logic exp);
    check(nm, {31'h0, seen}, {31'h0, exp});
  endtask

  task print_verdict;
    $display("Checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task hang;
    bad_count++;
    $display("Error handshake expected answer seen none");
    print_verdict();
  endtask

  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    bq.push_back(er);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) hang();
  endtask

  // A zero mask marks a poll whose data is not compared
  task axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    @(posedge clk);
    rq.push_back({m, e});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        resWord = rdata;
        break;
      end
    end
    if (n == 100) hang();
  endtask

  // Polls until the link is idle so no command is dropped as busy
  task lk(input logic [1:0] a, input logic [7:0] d, input logic rd);
    int n;
    axi_wr(HOST_CMD_OFF, {15'h0, rd, 6'h0, a, d}, RESP_OKAY);
    for (n = 0; n < 20; n++) begin
      axi_rd(HOST_RES_OFF, 32'h0, 32'h0);
      if (!resWord[8]) break;
    end
    if (n == 20) hang();
  endtask

  task lrd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    lk(a, 8'h00, 1'b1);
    axi_rd(HOST_RES_OFF, {24'h0, m}, {24'h0, e});
  endtask

  always @(posedge clk) begin
    if (!rst && bvalid && bready && bq.size() > 0) check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
    if (!rst && rvalid && rready && rq.size() > 0) begin
      rexp = rq.pop_front();
      if (rexp[63:32] != 32'h0) begin
        check("rdata", rdata & rexp[63:32], rexp[31:0]);
        check("rresp", {30'h0, rresp}, {30'h0, RESP_OKAY});
      end
    end
  end

  initial begin
    int n;
    int i;
    logic [5:0] code;
    logic [5:0] vexp;
    seed = 32'hFA0A; bad_count = 0; num_checks = 0; rst = 1'b1;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    vbatBelowShort = 1'b1; vbatBelowReg = 1'b1; vbatBelowRecharge = 1'b0; vbatBelowWeak = 1'b0;
    taperReached = 1'b0; vbusPorPulse = 1'b0; lowSideAboveMin = 1'b0; thermalShutdown = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk1("prechargeOn", prechargeOn, 1'b1);
    lrd(ADDR_STAT, 8'h1F, 8'h09);
    lrd(ADDR_CTRL, 8'h3F, CTRL_RST_VAL);
    lrd(ADDR_VREG, 8'h3F, VREG_RST_VAL);
    lrd(ADDR_CURR, 8'hFF, CURR_RST_VAL);
    vbatBelowShort <= 1'b0;
    lk(ADDR_CURR, 8'hFD, 1'b0);
    lrd(ADDR_STAT, 8'h1F, 8'h11);
    for (n = 0; n < 150 && currentCode !== 4'h6; n++) @(posedge clk);
    check("currentCode", {28'h0, currentCode}, 32'h6);
    check("inputCapCode", {30'h0, inputCapCode}, 32'h1);
    check("taperCode", {30'h0, taperCode}, 32'h3);
    chk1("prechargeOn", prechargeOn, 1'b0);
    repeat (6) begin
      @(posedge clk);
      lowSideAboveMin <= 1'($random(seed));
      repeat (3) @(posedge clk);
      chk1("syncRectOn", syncRectOn, lowSideAboveMin);
    end
    lk(ADDR_CTRL, 8'h0A, 1'b0);
    repeat (3) begin
      code = 6'($random(seed));
      vexp = (code > VREG_MAX_CODE) ? VREG_MAX_CODE : code;
      lk(ADDR_VREG, {2'h0, code}, 1'b0);
      lrd(ADDR_VREG, 8'h3F, {2'h0, vexp});
    end
    repeat (5) begin
      lk(ADDR_CTRL, 8'h0A, 1'b0);
      lrd(ADDR_CTRL, 8'h08, 8'h00);
      repeat (100) @(posedge clk);
    end
    check("regVoltageCode", {26'h0, regVoltageCode}, {26'h0, vexp});
    repeat (SHORT_CYC + 50) @(posedge clk);
    check("inputCapCode", {30'h0, inputCapCode}, 32'h0);
    check("regVoltageCode", {26'h0, regVoltageCode}, {26'h0, VREG_RST_VAL[5:0]});
    lrd(ADDR_STAT, 8'h1F, 8'h09);
    vbatBelowReg <= 1'b0;
    taperReached <= 1'b1;
    repeat (20) @(posedge clk);
    chk1("chargerOn", chargerOn, 1'b1);
    lk(ADDR_CTRL, 8'h0B, 1'b0);
    repeat (10) @(posedge clk);
    chk1("chargerOn", chargerOn, 1'b0);
    lrd(ADDR_STAT, 8'h07, {5'h0, COND_DONE});
    vbatBelowWeak <= 1'b1; vbusPorPulse <= 1'b1; taperReached <= 1'b0;
    @(posedge clk);
    vbusPorPulse <= 1'b0;
    repeat (4) @(posedge clk);
    chk1("chargerOn", chargerOn, 1'b1);
    vbatBelowWeak <= 1'b0; taperReached <= 1'b1;
    repeat (10) @(posedge clk);
    vbatBelowRecharge <= 1'b1; taperReached <= 1'b0;
    repeat (10) @(posedge clk);
    chk1("chargerOn", chargerOn, 1'b1);
    vbatBelowRecharge <= 1'b0; vbatBelowReg <= 1'b1;
    for (i = 0; i < 4; i++) begin
      lk(ADDR_CTRL, {2'h0, 2'(i), 4'hA}, 1'b0);
      repeat (4) @(posedge clk);
      chk1("boostOn", boostOn, i == 1);
      chk1("chargerOn", chargerOn, i == 0);
    end
    lk(ADDR_CTRL, 8'h08, 1'b0);
    chk1("chargerOn", chargerOn, 1'b0);
    lk(ADDR_CTRL, 8'h0A, 1'b0);
    chk1("chargerOn", chargerOn, 1'b1);
    lk(ADDR_CURR, 8'h3D, 1'b0);
    lk(ADDR_CTRL, 8'h0E, 1'b0);
    lrd(ADDR_CURR, 8'hFF, CURR_RST_VAL);
    lk(ADDR_CURR, 8'h01, 1'b0);
    thermalShutdown <= 1'b1;
    repeat (4) @(posedge clk);
    chk1("switchEn", switchEn, 1'b0);
    repeat (SHORT_CYC + 100) @(posedge clk);
    thermalShutdown <= 1'b0;
    repeat (2) @(posedge clk);
    check("inputCapCode", {30'h0, inputCapCode}, 32'h1);
    repeat (SHORT_CYC + 20) @(posedge clk);
    check("inputCapCode", {30'h0, inputCapCode}, 32'h0);
    repeat (LONG_CYC + 100) @(posedge clk);
    chk1("chargerOn", chargerOn, 1'b0);
    lrd(ADDR_STAT, 8'h07, {5'h0, COND_CHARGING});
    lrd(ADDR_STAT, 8'h07, {5'h0, COND_FAULT});
    axi_rd(HOST_RES_OFF, 32'h200, 32'h0);
    lk(ADDR_CTRL, 8'h0A, 1'b0);
    lrd(ADDR_STAT, 8'h07, {5'h0, COND_FAULT});
    repeat (2600) @(posedge clk);
    axi_rd(HOST_RES_OFF, 32'h200, 32'h200);
    axi_wr(4'h8, 32'h0, RESP_SLVERR);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    lrd(ADDR_STAT, 8'h1F, 8'h09);
    print_verdict();
  end
endmodule
`default_nettype wire
